// [rtl/lal_ack_top.sv]
// Latch clearing logic for indicators, output relays, SCADA signals, trips.
// Assumes all sources and clear sources are synchronous to aclk.
// Behaviour
// - Each LED has its own clear source releasing only that LED.
// - Each output relay has its own clear source releasing that output.
// - Each switchgear has its own clear source releasing its trip latch.
// - Without remote permit, group clear sources and SCADA clears are ignored.
// - SCADA communication clear requests need the same remote permit.
// - Group output clear source releases all output relays when permitted.
// - Group SCADA clear source releases all SCADA signals when permitted.
// - Protection or general alarm rise releases LEDs in clear-on-alarm mode.
// - Clear-on-alarm is chosen per LED; others ignore alarms.
// - Group LED clear source releases all LEDs when permitted.
// - A latch only releases while its setting source is inactive.
// - An output latch releases only after its off-delay has elapsed.
// - Without permit only panel clears act; others drop silently.
//
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module lal_ack_top
  import lal_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [LAL_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [LAL_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [LAL_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [LAL_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire lal_vec_s latch_src,
  input wire logic [LAL_NUM_LED-1:0] led_clear_source,
  input wire logic [LAL_NUM_OUT-1:0] output_clear_source,
  input wire logic [LAL_NUM_SG-1:0] trip_latch_clear_source,
  input wire logic all_indicator_clear_source,
  input wire logic all_output_relay_clear_source,
  input wire logic all_scada_clear_source,
  input wire logic [LAL_NUM_ALARM-1:0] prot_alarm,
  input wire logic general_alarm,
  input wire logic panel_clear,
  output lal_vec_s latched
);

  // Edge history of every clear source
  typedef struct packed {
    logic [LAL_NUM_LED-1:0] led;
    logic [LAL_NUM_OUT-1:0] outp;
    logic [LAL_NUM_SG-1:0] trip;
    logic grp_led;
    logic grp_out;
    logic grp_scada;
    logic [LAL_NUM_ALARM-1:0] alarm;
    logic gen_alarm;
    logic panel;
  } lal_clr_src_s;

  lal_clr_src_s cs_now;
  lal_clr_src_s cs_r;
  lal_clr_src_s cs_rise;

  logic permit_r, permit_nxt;
  logic [LAL_NUM_LED-1:0] led_mode_r, led_mode_nxt;
  logic [3:0] cmd_r, cmd_nxt;
  logic [31:0] offdly0_r, offdly0_nxt, offdly1_r, offdly1_nxt;
  logic [31:0] led_mode_word;

  logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic [LAL_ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic do_write;

  logic alarm_rise, panel_rise;
  logic [LAL_NUM_LED-1:0] led_other;
  logic [LAL_NUM_OUT-1:0] out_req, out_rel, out_pend;
  lal_vec_s clr;

  assign cs_now = '{led: led_clear_source, outp: output_clear_source,
                    trip: trip_latch_clear_source,
                    grp_led: all_indicator_clear_source,
                    grp_out: all_output_relay_clear_source,
                    grp_scada: all_scada_clear_source,
                    alarm: prot_alarm, gen_alarm: general_alarm,
                    panel: panel_clear};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs_r <= '0;
    end else begin
      cs_r <= cs_now;
    end
  end

  // Clear sources act on becoming active, not on level
  assign cs_rise = cs_now & ~cs_r;
  assign alarm_rise = (|cs_rise.alarm) | cs_rise.gen_alarm;
  assign panel_rise = cs_rise.panel;

  // Clear composition; panel is the only path the permit cannot block
  always_comb begin
    led_other = '0;
    clr = '0;
    out_req = '0;
    if (permit_r) begin
      led_other = cs_rise.led;
      if (cs_rise.grp_led || cmd_r[LAL_CMD_LED_BIT]) begin
        led_other = '1;
      end
      clr.led = led_other | (led_mode_r & {LAL_NUM_LED{alarm_rise}});
      out_req = cs_rise.outp;
      if (cs_rise.grp_out || cmd_r[LAL_CMD_OUT_BIT]) begin
        out_req = '1;
      end
      if (cs_rise.grp_scada || cmd_r[LAL_CMD_SCADA_BIT]) begin
        clr.scada = '1;
      end
      clr.trip = cs_rise.trip;
      if (cmd_r[LAL_CMD_TRIP_BIT]) begin
        clr.trip = '1;
      end
    end
    if (panel_rise) begin
      led_other = '1;
      clr.led = '1;
      clr.scada = '1;
      clr.trip = '1;
      out_req = '1;
    end
    clr.outp = out_rel;
  end

  lal_off_delay #(
    .N(LAL_NUM_OUT)
  ) u_off_delay (
    .aclk(aclk),
    .aresetn(aresetn),
    .req(out_req),
    .dly_cfg({offdly1_r, offdly0_r}),
    .release_p(out_rel),
    .pending(out_pend)
  );

  lal_latch_bank #(
    .N($bits(lal_vec_s))
  ) u_latches (
    .aclk(aclk),
    .aresetn(aresetn),
    .src(latch_src),
    .clr(clr),
    .latched(latched)
  );

  // AXI4-Lite slave: address and data taken in either order
  assign s_axi_awready = !aw_have_r && !bvalid_r;
  assign s_axi_wready = !w_have_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign do_write = aw_have_r && w_have_r;

  always_comb begin
    aw_have_nxt = aw_have_r;
    w_have_nxt = w_have_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    permit_nxt = permit_r;
    led_mode_nxt = led_mode_r;
    offdly0_nxt = offdly0_r;
    offdly1_nxt = offdly1_r;
    cmd_nxt = '0;
    led_mode_word = lal_merge(32'(led_mode_r), wdata_r, wstrb_r);
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (do_write) begin
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = LAL_RESP_OKAY;
      case (awaddr_r)
        LAL_REG_CTRL: begin
          if (wstrb_r[0]) begin
            permit_nxt = wdata_r[LAL_CTRL_PERMIT_BIT];
          end
        end
        LAL_REG_LED_MODE: begin
          led_mode_nxt = led_mode_word[LAL_NUM_LED-1:0];
        end
        LAL_REG_CMD: begin
          if (wstrb_r[0]) begin
            cmd_nxt = wdata_r[3:0];
          end
        end
        LAL_REG_OFFDLY0: offdly0_nxt = lal_merge(offdly0_r, wdata_r, wstrb_r);
        LAL_REG_OFFDLY1: offdly1_nxt = lal_merge(offdly1_r, wdata_r, wstrb_r);
        LAL_REG_LED_STAT, LAL_REG_OUT_STAT, LAL_REG_SCADA_STAT,
        LAL_REG_TRIP_STAT: begin
        end
        default: bresp_nxt = LAL_RESP_SLVERR;
      endcase
    end
  end

  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = LAL_RESP_OKAY;
      rdata_nxt = '0;
      case (s_axi_araddr)
        LAL_REG_CTRL: rdata_nxt[LAL_CTRL_PERMIT_BIT] = permit_r;
        LAL_REG_LED_MODE: rdata_nxt[LAL_NUM_LED-1:0] = led_mode_r;
        LAL_REG_CMD: rdata_nxt = '0;
        LAL_REG_LED_STAT: rdata_nxt[LAL_NUM_LED-1:0] = latched.led;
        LAL_REG_OUT_STAT: begin
          rdata_nxt[LAL_NUM_OUT-1:0] = latched.outp;
          rdata_nxt[LAL_OUT_PEND_LSB +: LAL_NUM_OUT] = out_pend;
        end
        LAL_REG_SCADA_STAT: rdata_nxt[LAL_NUM_SCADA-1:0] = latched.scada;
        LAL_REG_TRIP_STAT: rdata_nxt[LAL_NUM_SG-1:0] = latched.trip;
        LAL_REG_OFFDLY0: rdata_nxt = offdly0_r;
        LAL_REG_OFFDLY1: rdata_nxt = offdly1_r;
        default: rresp_nxt = LAL_RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= LAL_RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= LAL_RESP_OKAY;
      permit_r <= LAL_PERMIT_RST;
      led_mode_r <= LAL_LED_MODE_RST;
      offdly0_r <= LAL_OFFDLY_RST;
      offdly1_r <= LAL_OFFDLY_RST;
      cmd_r <= '0;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      permit_r <= permit_nxt;
      led_mode_r <= led_mode_nxt;
      offdly0_r <= offdly0_nxt;
      offdly1_r <= offdly1_nxt;
      cmd_r <= cmd_nxt;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  led_single_a: assert property (permit_r && cs_rise.led[0]
    |-> clr.led[0]) else $error("LED clear source ignored");
  out_single_a: assert property (permit_r && cs_rise.outp[0]
    |-> out_req[0]) else $error("Output clear source ignored");
  trip_single_a: assert property (permit_r && cs_rise.trip[0]
    |-> clr.trip[0]) else $error("Trip clear source ignored");
  permit_gate_a: assert property (!permit_r && !panel_rise
    |-> clr.led == '0 && clr.scada == '0 && clr.trip == '0
        && out_req == '0) else $error("Clear passed without permit");
  scada_cmd_a: assert property (cmd_r[LAL_CMD_SCADA_BIT]
    |-> (&clr.scada) == (permit_r || panel_rise))
    else $error("SCADA command clear wrong");
  group_out_a: assert property (permit_r && cs_rise.grp_out |-> &out_req)
    else $error("Group output clear missed");
  group_scada_a: assert property (permit_r && cs_rise.grp_scada
    |=> ((latched.scada & ~$past(latch_src.scada)) == '0))
    else $error("Group SCADA clear missed");
  alarm_clear_a: assert property (permit_r && alarm_rise
    |-> (clr.led & led_mode_r) == led_mode_r)
    else $error("Alarm did not clear LED");
  alarm_mode_a: assert property (led_other == '0
    |-> (clr.led & ~led_mode_r) == '0)
    else $error("Alarm cleared LED in plain mode");
  group_led_a: assert property (permit_r && cs_rise.grp_led |-> &clr.led)
    else $error("Group LED clear missed");
  src_holds_a: assert property (1'b1
    |=> ((latched & $past(latch_src)) == $past(latch_src)))
    else $error("Latch not set by active source");
  out_delay_a: assert property ((out_req[0] && offdly0_r[7:0] == 8'h05)
    ##1 (!out_req[0])[*6] |-> out_rel[0] && !$past(out_rel[0]))
    else $error("Off-delay release at wrong cycle");
  out_only_rel_a: assert property (out_rel == '0
    |=> ((~latched.outp & $past(latched.outp)) == '0))
    else $error("Output released without delay");
  hold_state_a: assert property (clr.led == '0
    |=> ((~latched.led & $past(latched.led)) == '0))
    else $error("LED latch dropped without clear");

  alarm_clear_c: cover property (permit_r && alarm_rise && led_mode_r != '0);
  out_release_c: cover property (out_req[0] ##[1:20] out_rel[0]);
  panel_clear_c: cover property (!permit_r && panel_rise);
  blocked_clear_c: cover property (!permit_r && cs_rise.grp_led);

endmodule
`default_nettype wire

// [include/lal_pkg.sv]
// Constants, register map and carrier types for the latch clearing block.
// Assumes a single 100 MHz clock domain and an AXI4-Lite register master.
package lal_pkg;

  localparam int LAL_NUM_LED = 14;
  localparam int LAL_NUM_OUT = 8;
  localparam int LAL_NUM_SCADA = 8;
  localparam int LAL_NUM_SG = 2;
  localparam int LAL_NUM_ALARM = 8;
  localparam int LAL_DLY_W = 8;
  localparam int LAL_ADDR_W = 8;
  localparam int LAL_DATA_W = 32;

  // Register byte addresses
  localparam logic [7:0] LAL_REG_CTRL = 8'h00;
  localparam logic [7:0] LAL_REG_LED_MODE = 8'h04;
  localparam logic [7:0] LAL_REG_CMD = 8'h08;
  localparam logic [7:0] LAL_REG_LED_STAT = 8'h0C;
  localparam logic [7:0] LAL_REG_OUT_STAT = 8'h10;
  localparam logic [7:0] LAL_REG_SCADA_STAT = 8'h14;
  localparam logic [7:0] LAL_REG_TRIP_STAT = 8'h18;
  localparam logic [7:0] LAL_REG_OFFDLY0 = 8'h1C;
  localparam logic [7:0] LAL_REG_OFFDLY1 = 8'h20;

  // Field positions
  localparam int LAL_CTRL_PERMIT_BIT = 0;
  localparam int LAL_CMD_LED_BIT = 0;
  localparam int LAL_CMD_OUT_BIT = 1;
  localparam int LAL_CMD_SCADA_BIT = 2;
  localparam int LAL_CMD_TRIP_BIT = 3;
  localparam int LAL_OUT_PEND_LSB = 8;

  // Reset values
  localparam logic LAL_PERMIT_RST = 1'b0;
  localparam logic [LAL_NUM_LED-1:0] LAL_LED_MODE_RST = 14'h0000;
  localparam logic [31:0] LAL_OFFDLY_RST = 32'h0000_0000;

  localparam logic [1:0] LAL_RESP_OKAY = 2'b00;
  localparam logic [1:0] LAL_RESP_SLVERR = 2'b10;

  // One bit per latched object, in every category
  typedef struct packed {
    logic [LAL_NUM_SG-1:0] trip;
    logic [LAL_NUM_SCADA-1:0] scada;
    logic [LAL_NUM_OUT-1:0] outp;
    logic [LAL_NUM_LED-1:0] led;
  } lal_vec_s;

  // Byte-lane merge for register writes
  function automatic logic [31:0] lal_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

endpackage

// [rtl/lal_latch_bank.sv]
// Bank of latches: set by source, released by a clear while source is low.
// Assumes sources and clears come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module lal_latch_bank #(
  parameter int N = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [N-1:0] src,
  input wire logic [N-1:0] clr,
  output logic [N-1:0] latched
);
  logic [N-1:0] lat_r;
  logic [N-1:0] lat_nxt;

  always_comb begin
    // Active source always wins over a clear
    lat_nxt = (lat_r | src) & ~(clr & ~src);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lat_r <= '0;
    end else begin
      lat_r <= lat_nxt;
    end
  end

  assign latched = lat_r;
endmodule
`default_nettype wire

// [rtl/lal_off_delay.sv]
// Per-output off-delay: a clear request is released after its count runs out.
// Delay 0 releases one cycle after the request; a new request restarts.
`timescale 1ns/1ps
`default_nettype none
module lal_off_delay
  import lal_pkg::*;
#(
  parameter int N = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [N-1:0] req,
  input wire logic [N*LAL_DLY_W-1:0] dly_cfg,
  output logic [N-1:0] release_p,
  output logic [N-1:0] pending
);
  logic [N-1:0] pend_r;
  logic [N-1:0] pend_nxt;
  logic [LAL_DLY_W-1:0] cnt_r [N];
  logic [LAL_DLY_W-1:0] cnt_nxt [N];

  always_comb begin
    for (int i = 0; i < N; i++) begin
      pend_nxt[i] = pend_r[i];
      cnt_nxt[i] = cnt_r[i];
      release_p[i] = 1'b0;
      if (req[i]) begin
        pend_nxt[i] = 1'b1;
        cnt_nxt[i] = dly_cfg[i*LAL_DLY_W +: LAL_DLY_W];
      end else if (pend_r[i]) begin
        if (cnt_r[i] == '0) begin
          release_p[i] = 1'b1;
          pend_nxt[i] = 1'b0;
        end else begin
          cnt_nxt[i] = cnt_r[i] - 1'b1;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_r <= '0;
      for (int i = 0; i < N; i++) begin
        cnt_r[i] <= '0;
      end
    end else begin
      pend_r <= pend_nxt;
      for (int i = 0; i < N; i++) begin
        cnt_r[i] <= cnt_nxt[i];
      end
    end
  end

  assign pending = pend_r;
endmodule
`default_nettype wire

// [bench/lal_src_model.sv]
// Model of the relay signals feeding the latch block: sources, clears, alarms.
// Assumes the bench calls its tasks just after a rising edge of aclk.
`timescale 1ns/1ps
`default_nettype none
module lal_src_model
  import lal_pkg::*;
(
  input wire logic aclk,
  output var lal_vec_s latch_src,
  output logic [LAL_NUM_LED-1:0] led_clear_source,
  output logic [LAL_NUM_OUT-1:0] output_clear_source,
  output logic [LAL_NUM_SG-1:0] trip_latch_clear_source,
  output logic all_indicator_clear_source,
  output logic all_output_relay_clear_source,
  output logic all_scada_clear_source,
  output logic [LAL_NUM_ALARM-1:0] prot_alarm,
  output logic general_alarm,
  output logic panel_clear
);
  initial begin
    latch_src = '0;
    led_clear_source = '0;
    output_clear_source = '0;
    trip_latch_clear_source = '0;
    all_indicator_clear_source = 1'b0;
    all_output_relay_clear_source = 1'b0;
    all_scada_clear_source = 1'b0;
    prot_alarm = '0;
    general_alarm = 1'b0;
    panel_clear = 1'b0;
  end

  task automatic set_src(input lal_vec_s v);
    latch_src <= v;
  endtask

  // One-cycle pulse; returns a cycle later so the next pulse rises again
  task automatic pulse(input int kind, input logic [31:0] m);
    case (kind)
      0: led_clear_source <= m[LAL_NUM_LED-1:0];
      1: output_clear_source <= m[LAL_NUM_OUT-1:0];
      2: trip_latch_clear_source <= m[LAL_NUM_SG-1:0];
      3: all_indicator_clear_source <= m[0];
      4: all_output_relay_clear_source <= m[0];
      5: all_scada_clear_source <= m[0];
      6: begin
        prot_alarm <= m[LAL_NUM_ALARM-1:0];
        general_alarm <= m[LAL_NUM_ALARM];
      end
      default: panel_clear <= m[0];
    endcase
    @(posedge aclk);
    led_clear_source <= '0;
    output_clear_source <= '0;
    trip_latch_clear_source <= '0;
    all_indicator_clear_source <= 1'b0;
    all_output_relay_clear_source <= 1'b0;
    all_scada_clear_source <= 1'b0;
    prot_alarm <= '0;
    general_alarm <= 1'b0;
    panel_clear <= 1'b0;
    @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// [bench/lal_ack_top_test.sv]
// Self-checking bench for the latch clearing block over AXI4-Lite.
// Assumes lal_pkg, the design files and lal_src_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module lal_ack_top_test;
  import lal_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = '0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = '0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  lal_vec_s latch_src, latched, v;
  logic [13:0] led_clr;
  logic [7:0] out_clr, alarm;
  logic [1:0] trip_clr;
  logic grp_led, grp_out, grp_scd, gen_alarm, panel;
  logic [33:0] exp_r[$];
  logic [1:0] exp_b[$];
  logic [33:0] er;
  logic [31:0] rnd = 32'h60f7_9b74;
  logic [13:0] mode;
  int fails = 0;
  int total_checks = 0;

  always #5 aclk = ~aclk;

  lal_ack_top lal_ack_top_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .latch_src(latch_src),
    .led_clear_source(led_clr), .output_clear_source(out_clr),
    .trip_latch_clear_source(trip_clr),
    .all_indicator_clear_source(grp_led),
    .all_output_relay_clear_source(grp_out),
    .all_scada_clear_source(grp_scd), .prot_alarm(alarm),
    .general_alarm(gen_alarm), .panel_clear(panel), .latched(latched));

  lal_src_model lal_src_model_inst (.aclk(aclk), .latch_src(latch_src),
    .led_clear_source(led_clr), .output_clear_source(out_clr),
    .trip_latch_clear_source(trip_clr),
    .all_indicator_clear_source(grp_led),
    .all_output_relay_clear_source(grp_out),
    .all_scada_clear_source(grp_scd), .prot_alarm(alarm),
    .general_alarm(gen_alarm), .panel_clear(panel));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic finish_test();
    if (fails == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    bit aw_done;
    bit w_done;
    aw_done = 0;
    w_done = 0;
    exp_b.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_done = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_done = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    // One idle edge so a following call never re-drives in this step
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    exp_r.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic chk_all(input logic [31:0] l, input logic [31:0] o,
                         input logic [31:0] s, input logic [31:0] t);
    rd(LAL_REG_LED_STAT, l, LAL_RESP_OKAY);
    rd(LAL_REG_OUT_STAT, o, LAL_RESP_OKAY);
    rd(LAL_REG_SCADA_STAT, s, LAL_RESP_OKAY);
    rd(LAL_REG_TRIP_STAT, t, LAL_RESP_OKAY);
  endtask

  // Sources rise then fall, so only the latches keep the state
  task automatic relatch(input lal_vec_s x);
    lal_src_model_inst.set_src(x);
    repeat (2) @(posedge aclk);
    lal_src_model_inst.set_src('0);
    repeat (2) @(posedge aclk);
  endtask

  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      er = (exp_r.size() > 0) ? exp_r.pop_front() : 34'h3_ffff_ffff;
      cmp("rdata", er[31:0], s_axi_rdata);
      cmp("rresp", {30'h0, er[33:32]}, {30'h0, s_axi_rresp});
    end
    if (s_axi_bvalid && s_axi_bready)
      cmp("bresp", {30'h0, exp_b.pop_front()}, {30'h0, s_axi_bresp});
  end

  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    finish_test();
  end

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 9; i++)
      rd(8'(4 * i), 32'h0000_0000, LAL_RESP_OKAY);
    rd(8'h40, 32'h0000_0000, LAL_RESP_SLVERR);
    wr(8'h44, rnd, LAL_RESP_SLVERR);
    // Without permit every non-panel clear is dropped
    relatch('1);
    for (int k = 0; k < 7; k++)
      lal_src_model_inst.pulse(k, 32'hffff_ffff);
    wr(LAL_REG_CMD, 32'h0000_000f, LAL_RESP_OKAY);
    repeat (4) @(posedge aclk);
    chk_all(32'h3fff, 32'h00ff, 32'h00ff, 32'h0003);
    wr(LAL_REG_CTRL, 32'h0000_0001, LAL_RESP_OKAY);
    rd(LAL_REG_CTRL, 32'h0000_0001, LAL_RESP_OKAY);
    // LED 3 still driven by its source, so its clear is lost
    v = '0;
    v.led = 14'h0008;
    lal_src_model_inst.set_src(v);
    lal_src_model_inst.pulse(0, 32'h0000_0018);
    lal_src_model_inst.set_src('0);
    lal_src_model_inst.pulse(2, 32'h0000_0002);
    wr(LAL_REG_OFFDLY0, 32'h0000_0005, LAL_RESP_OKAY);
    rd(LAL_REG_OFFDLY0, 32'h0000_0005, LAL_RESP_OKAY);
    lal_src_model_inst.pulse(1, 32'h0000_0001);
    rd(LAL_REG_OUT_STAT, 32'h0000_01ff, LAL_RESP_OKAY);
    repeat (10) @(posedge aclk);
    chk_all(32'h3fef, 32'h00fe, 32'h00ff, 32'h0001);
    for (int k = 3; k < 6; k++)
      lal_src_model_inst.pulse(k, 32'h0000_0001);
    repeat (10) @(posedge aclk);
    chk_all(32'h0000, 32'h0000, 32'h0000, 32'h0001);
    // Each command bit (LED, output, SCADA, trip), with permit
    relatch('1);
    for (int b = 0; b < 4; b++)
      wr(LAL_REG_CMD, 32'h0000_0001 << b, LAL_RESP_OKAY);
    repeat (10) @(posedge aclk);
    chk_all(32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    // Each alarm input and the general alarm, random mode per round
    for (int a = 0; a <= LAL_NUM_ALARM; a++) begin
      rnd = lfsr(rnd);
      mode = rnd[13:0];
      wr(LAL_REG_LED_MODE, rnd, LAL_RESP_OKAY);
      rd(LAL_REG_LED_MODE, {18'h0, mode}, LAL_RESP_OKAY);
      v = '0;
      v.led = '1;
      relatch(v);
      lal_src_model_inst.pulse(6, 32'h0000_0001 << a);
      rd(LAL_REG_LED_STAT, {18'h0, ~mode}, LAL_RESP_OKAY);
    end
    // Panel clear still acts with permit off
    wr(LAL_REG_CTRL, 32'h0000_0000, LAL_RESP_OKAY);
    relatch('1);
    lal_src_model_inst.pulse(7, 32'h0000_0001);
    repeat (10) @(posedge aclk);
    chk_all(32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    if (exp_r.size() != 0 || exp_b.size() != 0)
      fails++;
    finish_test();
  end
endmodule
`default_nettype wire
